/* File: wake_reset_pkg.sv */
`default_nettype none
package wake_reset_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [13:0] IDX_SUPPLY_STATE = 14'h00F9;
	localparam logic [13:0] IDX_WAKE_DURATION = 14'h2880;
	localparam logic [13:0] IDX_RESET_FLAGS = 14'h28B0;
	localparam logic [13:0] IDX_WAKE_FLAGS = 14'h28B1;
	localparam logic [13:0] IDX_WAKE_ARM = 14'h28B2;
	localparam logic [13:0] IDX_WATCHDOG = 14'h28B4;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int POS_COLD_START = 7;
	localparam int POS_RESET_PIN = 6;
	localparam int POS_SOFT_RESET = 5;
	localparam int POS_WDOG_OVF = 4;
	localparam int POS_EMU_RESET = 3;
	localparam int POS_BAD_SUPPLY = 2;
	localparam int POS_TIMER_WAKE = 5;
	localparam int POS_RX_WAKE = 4;
	localparam int POS_BUTTON_WAKE = 3;
	localparam int POS_PIN4_WAKE = 2;
	localparam int POS_PIN52_WAKE = 1;
	localparam int POS_PIN55_WAKE = 0;
	localparam int POS_ARM = 5;
	localparam int POS_WDOG_RESTART = 7;
	localparam int POS_TRIM_FAST = 5;

	// ------------------------------------------------------------
	// Supply state codes and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] CODE_POWER_OK = 3'h0;
	localparam logic [2:0] CODE_POWER_LOW = 3'h1;
	localparam logic [2:0] CODE_BATT_CORE_OK = 3'h2;
	localparam logic [2:0] CODE_BATT_CORE_LOW = 3'h3;
	localparam logic [2:0] CODE_BATT_FAIL = 3'h5;
	localparam logic [7:0] RST_WAKE_DURATION = 8'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

	// Supply comparator group, carried together
	typedef struct packed {
		logic analog_supply_low_ok;
		logic analog_supply_high_ok;
		logic core_supply_ok;
		logic core_above_low_limit;
	} supply_cmp_t;

	// Wake timer state, Gray coded along idle -> armed -> counting
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_ARMED = 2'b01,
		TMR_COUNT = 2'b11
	} timer_state_t;

endpackage
`default_nettype wire

/* File: wake_reset_status_logic.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_reset_status_logic
	import wake_reset_pkg::*;
#(
	parameter int SYNC_STAGES = 3,
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	// Avalon-MM slave, byte addressed
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Supply comparators (asynchronous pins)
	input wire supply_cmp_t supply_cmp,
	// Wake inputs (asynchronous pins)
	input wire logic wake_pin_a,
	input wire logic wake_pin_b,
	input wire logic wake_pin_c,
	input wire logic push_button_input,
	input wire logic receive_input,
	// Same-clock controls from the processor and configuration
	input wire logic [2:0] wake_pin_enable,
	input wire logic sleep_command,
	input wire logic display_only_command,
	input wire logic [7:0] core_voltage_trim_fuse,
	// Reset cause pulses from the reset generator, same clock
	input wire logic reset_pin_event,
	input wire logic soft_reset_event,
	input wire logic emulator_reset_event,
	input wire logic watchdog_overflow_event,
	input wire logic cold_start_event,
	input wire logic bad_supply_event,
	// Outputs
	output logic [2:0] supply_state_code,
	output logic flash_write_inhibit,
	output logic fast_clock_clear,
	output logic wake_request,
	output logic watchdog_restart
);

	// Word index match, used by every register decode
	function automatic logic reg_hit(input logic [15:0] addr,
			input logic [13:0] idx);
		reg_hit = (addr[15:2] == idx);
	endfunction

	localparam int NUM_PINS = 9;
	localparam logic [31:0] TICK_LAST = 32'(TICK_COUNT - 1);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Pins gathered into one vector for the generate loop below
	wire logic [NUM_PINS-1:0] pin_raw;
	assign pin_raw = {supply_cmp, wake_pin_a, wake_pin_b, wake_pin_c,
		push_button_input, receive_input};

	logic [NUM_PINS-1:0] pin_clean_q;
	logic [NUM_PINS-1:0] pin_prev_q;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
			logic [SYNC_STAGES-1:0] stage_q;
			// Clean value only moves once the last two stages agree,
			// so a metastable first stage is never looked at
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					stage_q <= '0;
					pin_clean_q[gi] <= 1'b0;
				end else begin
					stage_q <= {stage_q[SYNC_STAGES-2:0], pin_raw[gi]};
					if (stage_q[SYNC_STAGES-1] == stage_q[SYNC_STAGES-2]) begin
						pin_clean_q[gi] <= stage_q[SYNC_STAGES-1];
					end
				end
			end
		end
	endgenerate

	// Previous clean value for edge detection
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pin_prev_q <= '0;
		end else begin
			pin_prev_q <= pin_clean_q;
		end
	end

	wire supply_cmp_t cmp_s;
	wire logic [2:0] wake_pin_rise;
	wire logic button_rise;
	wire logic rx_fall;
	assign cmp_s = pin_clean_q[8:5];
	assign wake_pin_rise = pin_clean_q[4:2] & ~pin_prev_q[4:2];
	assign button_rise = pin_clean_q[1] & ~pin_prev_q[1];
	// Receive idles high; a start bit is the first sign of activity
	assign rx_fall = ~pin_clean_q[0] & pin_prev_q[0];

	// ------------------------------------------------------------
	// Supply state encoding
	// ------------------------------------------------------------
	wire logic [2:0] code_d;
	wire logic on_battery;
	wire logic batt_core_low;
	assign on_battery = ~cmp_s.analog_supply_low_ok
		& ~cmp_s.analog_supply_high_ok;
	assign batt_core_low = on_battery & ~cmp_s.core_supply_ok
		& cmp_s.core_above_low_limit;
	// High comparator alone cannot occur electrically; treated as good
	assign code_d =
		(cmp_s.analog_supply_high_ok) ? CODE_POWER_OK :
		(cmp_s.analog_supply_low_ok) ? CODE_POWER_LOW :
		(cmp_s.core_supply_ok) ? CODE_BATT_CORE_OK :
		(cmp_s.core_above_low_limit) ? CODE_BATT_CORE_LOW :
		CODE_BATT_FAIL;

	logic [2:0] code_q;
	logic inhibit_q;
	logic fast_clear_q;
	// Registered so the outputs never glitch between comparator moves
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			code_q <= CODE_POWER_OK;
			inhibit_q <= 1'b0;
			fast_clear_q <= 1'b0;
		end else begin
			code_q <= code_d;
			inhibit_q <= batt_core_low;
			fast_clear_q <= batt_core_low
				& core_voltage_trim_fuse[POS_TRIM_FAST];
		end
	end

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic wait_q;
	logic [31:0] rdata_q;
	wire logic bus_req;
	wire logic bus_done;
	wire logic wr_lane0;
	assign bus_req = avs_read | avs_write;
	// Transfer completes on the edge where the master sees wait low
	assign bus_done = bus_req & ~wait_q;
	assign wr_lane0 = avs_write & bus_done & avs_byteenable[0];
	wire logic wr_duration;
	wire logic wr_arm;
	wire logic wr_wdog;
	assign wr_duration = wr_lane0 & reg_hit(avs_address, IDX_WAKE_DURATION);
	assign wr_arm = wr_lane0 & reg_hit(avs_address, IDX_WAKE_ARM)
		& avs_writedata[POS_ARM];
	assign wr_wdog = wr_lane0 & reg_hit(avs_address, IDX_WATCHDOG)
		& avs_writedata[POS_WDOG_RESTART];

	// ------------------------------------------------------------
	// Wake timer
	// ------------------------------------------------------------
	timer_state_t tmr_q;
	logic [7:0] duration_q;
	logic [7:0] count_q;
	logic [31:0] div_q;
	logic expire_q;
	wire logic asleep;
	wire logic sec_tick;
	wire logic expire_d;
	assign asleep = sleep_command | display_only_command;
	assign sec_tick = (div_q == TICK_LAST);
	// Count runs duration..0, expiring on the tick after zero
	assign expire_d = (tmr_q == TMR_COUNT) & asleep & sec_tick
		& (count_q == 8'h00);

	// Duration register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			duration_q <= RST_WAKE_DURATION;
		end else if (wr_duration) begin
			duration_q <= avs_writedata[7:0];
		end
	end

	// One-second divider; held while not counting so the first
	// second after sleep starts is a full one
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
		end else if (tmr_q != TMR_COUNT || !asleep || sec_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 32'h0000_0001;
		end
	end

	// Timer state machine
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tmr_q <= TMR_IDLE;
			count_q <= 8'h00;
			expire_q <= 1'b0;
		end else begin
			expire_q <= expire_d;
			if (wr_arm) begin
				tmr_q <= TMR_ARMED;
				count_q <= duration_q;
			end else begin
				case (tmr_q)
					TMR_IDLE: begin
						tmr_q <= TMR_IDLE;
					end
					TMR_ARMED: begin
						if (asleep) begin
							tmr_q <= TMR_COUNT;
						end
					end
					TMR_COUNT: begin
						if (expire_d) begin
							tmr_q <= TMR_IDLE;
						end else if (asleep && sec_tick) begin
							count_q <= count_q - 8'h01;
						end
					end
					default: begin
						tmr_q <= TMR_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Wake flags
	// ------------------------------------------------------------
	logic [2:0] pin_flag_q;
	logic timer_flag_q;
	logic button_flag_q;
	logic rx_flag_q;
	logic asleep_prev_q;
	// Entering sleep clears the timer, button and receive flags;
	// a wake event in that same cycle still wins
	wire logic sleep_entry;
	assign sleep_entry = asleep & ~asleep_prev_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			asleep_prev_q <= 1'b0;
			timer_flag_q <= 1'b0;
			button_flag_q <= 1'b0;
			rx_flag_q <= 1'b0;
		end else begin
			asleep_prev_q <= asleep;
			if (expire_d) begin
				timer_flag_q <= 1'b1;
			end else if (sleep_entry) begin
				timer_flag_q <= 1'b0;
			end
			if (asleep && button_rise) begin
				button_flag_q <= 1'b1;
			end else if (sleep_entry) begin
				button_flag_q <= 1'b0;
			end
			if (asleep && rx_fall) begin
				rx_flag_q <= 1'b1;
			end else if (sleep_entry) begin
				rx_flag_q <= 1'b0;
			end
		end
	end

	// Pin flags: set by edge, held clear when not a wake source
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin_flag
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					pin_flag_q[gi] <= 1'b0;
				end else if (!wake_pin_enable[gi]) begin
					pin_flag_q[gi] <= 1'b0;
				end else if (wake_pin_rise[gi]) begin
					pin_flag_q[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// Wake request to the clock controller, any source
	logic wake_q;
	wire logic wake_any;
	assign wake_any = expire_q | (asleep & (button_rise | rx_fall
		| |(wake_pin_rise & wake_pin_enable)));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_any;
		end
	end

	// ------------------------------------------------------------
	// Reset cause flags
	// ------------------------------------------------------------
	// Sticky; only a power-down of this domain clears them, so the
	// cause survives the processor reset it describes
	logic [5:0] cause_q;
	wire logic [5:0] cause_in;
	assign cause_in = {cold_start_event, reset_pin_event, soft_reset_event,
		watchdog_overflow_event, emulator_reset_event, bad_supply_event};

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cause_q <= 6'h00;
		end else begin
			cause_q <= cause_q | cause_in;
		end
	end

	// ------------------------------------------------------------
	// Watchdog restart strobe
	// ------------------------------------------------------------
	logic wdog_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wdog_q <= 1'b0;
		end else begin
			wdog_q <= wr_wdog;
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire logic [7:0] wake_byte;
	wire logic [7:0] reset_byte;
	wire logic [7:0] arm_byte;
	wire logic [31:0] rdata_d;
	assign wake_byte = {2'b00, timer_flag_q, rx_flag_q, button_flag_q,
		pin_flag_q};
	assign reset_byte = {cause_q, 2'b00};
	assign arm_byte = {2'b00, (tmr_q != TMR_IDLE), 5'b00000};
	// Watchdog restart is write-only and reads as zero
	assign rdata_d =
		reg_hit(avs_address, IDX_SUPPLY_STATE) ? {29'h0, code_q} :
		reg_hit(avs_address, IDX_WAKE_DURATION) ? {24'h0, duration_q} :
		reg_hit(avs_address, IDX_RESET_FLAGS) ? {24'h0, reset_byte} :
		reg_hit(avs_address, IDX_WAKE_FLAGS) ? {24'h0, wake_byte} :
		reg_hit(avs_address, IDX_WAKE_ARM) ? {24'h0, arm_byte} :
		READ_UNMAPPED;

	// One wait state: data captured the cycle before wait drops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (bus_req && wait_q) begin
				wait_q <= 1'b0;
				rdata_q <= avs_read ? rdata_d : 32'h0000_0000;
			end else begin
				wait_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign supply_state_code = code_q;
	assign flash_write_inhibit = inhibit_q;
	assign fast_clock_clear = fast_clear_q;
	assign wake_request = wake_q;
	assign watchdog_restart = wdog_q;

endmodule // wake_reset_status_logic
`default_nettype wire

/* File: wake_reset_status_logic_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_reset_status_logic_sva
	import wake_reset_pkg::*;
#(
	parameter int SYNC_STAGES = 3,
	parameter int TICK_COUNT = 20
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire supply_cmp_t supply_cmp,
	input wire logic [7:0] core_voltage_trim_fuse,
	input wire logic [2:0] supply_state_code,
	input wire logic flash_write_inhibit,
	input wire logic fast_clock_clear,
	input wire logic wake_request,
	input wire logic watchdog_restart
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// Decode of the transfer completing in this cycle
	// ------------------------------------------------------------
	wire logic [13:0] idx = avs_address[15:2];
	wire logic done_rd = avs_read && !avs_waitrequest;
	wire logic wr_wd = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& idx == IDX_WATCHDOG && avs_writedata[POS_WDOG_RESTART];
	wire logic mapped = idx == IDX_SUPPLY_STATE || idx == IDX_WAKE_DURATION
		|| idx == IDX_RESET_FLAGS || idx == IDX_WAKE_FLAGS
		|| idx == IDX_WAKE_ARM || idx == IDX_WATCHDOG;
	// Priority decode of the comparators, highest supply first
	wire logic [2:0] code_exp = supply_cmp.analog_supply_high_ok ? CODE_POWER_OK
		: supply_cmp.analog_supply_low_ok ? CODE_POWER_LOW
		: supply_cmp.core_supply_ok ? CODE_BATT_CORE_OK
		: supply_cmp.core_above_low_limit ? CODE_BATT_CORE_LOW : CODE_BATT_FAIL;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request not answered in one cycle");
	// Eight quiet samples cover the pin synchroniser and the code register
	a_code_map: assert property ($stable(supply_cmp) [*8]
		|-> supply_state_code == code_exp) else $error("supply code wrong");
	a_inhibit_on: assert property (
		(supply_state_code == CODE_BATT_CORE_LOW) [*2] |-> flash_write_inhibit)
		else $error("flash write not inhibited");
	a_inhibit_off: assert property (
		(supply_state_code != CODE_BATT_CORE_LOW) [*2] |-> !flash_write_inhibit)
		else $error("flash write inhibited outside low core state");
	a_fast_clear: assert property (
		(supply_state_code == CODE_BATT_CORE_LOW
		&& core_voltage_trim_fuse[POS_TRIM_FAST]) [*2]
		|-> fast_clock_clear) else $error("fast clock not cleared");
	a_fast_keep: assert property (
		(!core_voltage_trim_fuse[POS_TRIM_FAST]) [*2] |-> !fast_clock_clear)
		else $error("fast clock cleared with fuse intact");
	a_wd_cause: assert property (watchdog_restart |-> $past(wr_wd))
		else $error("watchdog restart without a write");
	a_wd_effect: assert property (wr_wd |=> watchdog_restart
		##1 !watchdog_restart) else $error("watchdog restart pulse wrong");
	a_wake_single: assert property (wake_request |=> !wake_request)
		else $error("wake request longer than one cycle");
	a_rd_unmapped: assert property (done_rd && !mapped
		|-> avs_readdata == READ_UNMAPPED) else $error("unmapped read not zero");
	a_rd_code: assert property (done_rd && idx == IDX_SUPPLY_STATE
		|-> avs_readdata == {29'h0, $past(supply_state_code)})
		else $error("supply code read wrong");
endmodule // wake_reset_status_logic_sva
`default_nettype wire

/* File: wake_pins_model.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_pins_model
	import wake_reset_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire supply_cmp_t supply_set,
	input wire logic [4:0] edge_req,
	output supply_cmp_t supply_cmp,
	output logic wake_pin_a,
	output logic wake_pin_b,
	output logic wake_pin_c,
	output logic push_button_input,
	output logic receive_input
);
	logic [4:0] active_q;
	logic [3:0] hold_q;

	// Lines held for a clean burst, so the debounced edge is never ambiguous
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			active_q <= 5'h00;
			hold_q <= 4'h0;
		end else if (edge_req != 5'h00) begin
			active_q <= edge_req;
			hold_q <= 4'hC;
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end else begin
			active_q <= 5'h00;
		end
	end

	// Comparators follow the bench's supply setting
	assign supply_cmp = supply_set;
	assign wake_pin_a = active_q[0];
	assign wake_pin_b = active_q[1];
	assign wake_pin_c = active_q[2];
	assign push_button_input = active_q[3];
	assign receive_input = !active_q[4]; // Idles high
endmodule // wake_pins_model
`default_nettype wire

/* File: wake_reset_status_logic_test.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_reset_status_logic_test
	import wake_reset_pkg::*;
;
	localparam int TICKS = 20;
	localparam supply_cmp_t CMP_TAB [5] = '{4'hF, 4'h8, 4'h3, 4'h0, 4'h1};
	localparam logic [2:0] CODE_TAB [5] = '{CODE_POWER_OK, CODE_POWER_LOW,
		CODE_BATT_CORE_OK, CODE_BATT_FAIL, CODE_BATT_CORE_LOW};
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	supply_cmp_t supply_set = 4'hF;
	supply_cmp_t supply_cmp;
	logic [4:0] edge_req = 5'h00;
	logic pin_a, pin_b, pin_c, button, rx_line;
	logic [2:0] wake_pin_enable = 3'h0;
	logic sleep_command = 1'b0;
	logic display_only_command = 1'b0;
	logic [7:0] core_voltage_trim_fuse = 8'h20;
	logic [5:0] cause = 6'h00;
	logic [2:0] supply_state_code;
	logic flash_write_inhibit, fast_clock_clear, wake_request, watchdog_restart;
	logic [31:0] rd;
	logic [7:0] exp_rst;
	logic seen;
	int n_mismatch = 0;
	int n_compared = 0;
	int n;
	int n_wd = 0;

	always #10 clk_sys = ~clk_sys;

	// Restart pulses seen, so a stuck or doubled strobe shows up
	always @(posedge clk_sys) begin
		if (watchdog_restart === 1'b1) begin
			n_wd <= n_wd + 1;
		end
	end

	wake_reset_status_logic #(.TICK_COUNT(TICKS)) u_wake_reset_status_logic (
		.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_cmp(supply_cmp), .wake_pin_a(pin_a), .wake_pin_b(pin_b),
		.wake_pin_c(pin_c), .push_button_input(button),
		.receive_input(rx_line), .wake_pin_enable(wake_pin_enable),
		.sleep_command(sleep_command),
		.display_only_command(display_only_command),
		.core_voltage_trim_fuse(core_voltage_trim_fuse),
		.reset_pin_event(cause[4]), .soft_reset_event(cause[3]),
		.emulator_reset_event(cause[1]), .watchdog_overflow_event(cause[2]),
		.cold_start_event(cause[5]), .bad_supply_event(cause[0]),
		.supply_state_code(supply_state_code),
		.flash_write_inhibit(flash_write_inhibit),
		.fast_clock_clear(fast_clock_clear), .wake_request(wake_request),
		.watchdog_restart(watchdog_restart));

	wake_pins_model u_wake_pins_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.supply_set(supply_set), .edge_req(edge_req), .supply_cmp(supply_cmp),
		.wake_pin_a(pin_a), .wake_pin_b(pin_b), .wake_pin_c(pin_c),
		.push_button_input(button), .receive_input(rx_line));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [13:0] idx,
			input logic [7:0] d, output logic [31:0] q);
		int k;
		k = 0;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && k < 20) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 20) begin
			n_mismatch++;
			end_sim();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		check(q, exp);
	endtask

	// Counts edges until a wake request; a missing one ends the run
	task automatic wait_wake(output int c);
		c = 0;
		while (wake_request !== 1'b1 && c < 200) begin
			@(posedge clk_sys);
			c++;
		end
		if (c == 200) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd_chk(IDX_WAKE_DURATION, 32'h0000_0000);
		rd_chk(IDX_WAKE_FLAGS, 32'h0000_0000);
		rd_chk(IDX_RESET_FLAGS, 32'h0000_0000);
		rd_chk(IDX_WAKE_ARM, 32'h0000_0000);
		// Every supply state, ending in the low-core state
		for (int i = 0; i < 5; i++) begin
			supply_set <= CMP_TAB[i];
			repeat (10) @(posedge clk_sys);
			rd_chk(IDX_SUPPLY_STATE, {29'h0, CODE_TAB[i]});
			check({31'h0, flash_write_inhibit},
				{31'h0, CODE_TAB[i] == CODE_BATT_CORE_LOW});
			check({31'h0, fast_clock_clear},
				{31'h0, CODE_TAB[i] == CODE_BATT_CORE_LOW});
		end
		core_voltage_trim_fuse <= 8'h00;
		repeat (4) @(posedge clk_sys);
		check({31'h0, fast_clock_clear}, 32'h0000_0000);
		supply_set <= 4'hF;
		bus(1'b1, IDX_WATCHDOG, 8'h80, rd);
		bus(1'b1, IDX_WATCHDOG, 8'h7F, rd);
		rd_chk(IDX_WATCHDOG, 32'h0000_0000);
		check(32'(n_wd), 32'h0000_0001);
		bus(1'b1, 14'h0001, 8'h5A, rd);
		rd_chk(14'h0001, READ_UNMAPPED);
		bus(1'b1, IDX_WAKE_DURATION, 8'hA5, rd);
		rd_chk(IDX_WAKE_DURATION, 32'h0000_00A5);
		// Low byte lane disabled: the write must be ignored
		avs_byteenable <= 4'hE;
		bus(1'b1, IDX_WAKE_DURATION, 8'h3C, rd);
		avs_byteenable <= 4'hF;
		rd_chk(IDX_WAKE_DURATION, 32'h0000_00A5);
		// Pin flags: set on edges when enabled, held clear otherwise
		wake_pin_enable <= 3'h7;
		edge_req <= 5'h07;
		@(posedge clk_sys);
		edge_req <= 5'h00;
		repeat (20) @(posedge clk_sys);
		rd_chk(IDX_WAKE_FLAGS, 32'h0000_0007);
		wake_pin_enable <= 3'h5;
		edge_req <= 5'h02;
		@(posedge clk_sys);
		edge_req <= 5'h00;
		repeat (20) @(posedge clk_sys);
		rd_chk(IDX_WAKE_FLAGS, 32'h0000_0005);
		wake_pin_enable <= 3'h0;
		repeat (3) @(posedge clk_sys);
		rd_chk(IDX_WAKE_FLAGS, 32'h0000_0000);
		// Wake timer, shortest and a longer duration, both sleep modes
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, IDX_WAKE_DURATION, 8'(2 * j), rd);
			bus(1'b1, IDX_WAKE_ARM, 8'h20, rd);
			rd_chk(IDX_WAKE_ARM, 32'h0000_0020);
			seen = 1'b0;
			repeat (3 * TICKS) begin
				@(posedge clk_sys);
				seen = seen | (wake_request === 1'b1);
			end
			check({31'h0, seen}, 32'h0000_0000);
			display_only_command <= (j == 0);
			sleep_command <= (j == 1);
			@(posedge clk_sys);
			wait_wake(n);
			check({31'h0, n >= (2 * j + 1) * TICKS
				&& n <= (2 * j + 1) * TICKS + 4}, 32'h0000_0001);
			rd_chk(IDX_WAKE_FLAGS, 32'h0000_0020);
			display_only_command <= 1'b0;
			sleep_command <= 1'b0;
			rd_chk(IDX_WAKE_ARM, 32'h0000_0000);
		end
		// Button, then receive activity, each while asleep
		for (int j = 0; j < 2; j++) begin
			sleep_command <= 1'b1;
			repeat (3) @(posedge clk_sys);
			edge_req <= (j == 0) ? 5'h08 : 5'h10;
			@(posedge clk_sys);
			edge_req <= 5'h00;
			wait_wake(n);
			sleep_command <= 1'b0;
			rd_chk(IDX_WAKE_FLAGS, (j == 0) ? 32'h8 : 32'h10);
		end
		// Reset causes accumulate, one flag each
		exp_rst = 8'h00;
		for (int i = 0; i < 6; i++) begin
			cause <= 6'(1 << i);
			@(posedge clk_sys);
			cause <= 6'h00;
			exp_rst = exp_rst | 8'(4 << i);
			repeat (2) @(posedge clk_sys);
			rd_chk(IDX_RESET_FLAGS, {24'h0, exp_rst});
		end
		reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd_chk(IDX_RESET_FLAGS, 32'h0000_0000);
		rd_chk(IDX_WAKE_DURATION, 32'h0000_0000);
		end_sim();
	end
endmodule // wake_reset_status_logic_test

bind wake_reset_status_logic wake_reset_status_logic_sva #(
	.SYNC_STAGES(SYNC_STAGES), .TICK_COUNT(TICK_COUNT)
) u_wake_reset_status_logic_sva (.clk_sys(clk_sys), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.supply_cmp(supply_cmp), .core_voltage_trim_fuse(core_voltage_trim_fuse),
	.supply_state_code(supply_state_code),
	.flash_write_inhibit(flash_write_inhibit),
	.fast_clock_clear(fast_clock_clear), .wake_request(wake_request),
	.watchdog_restart(watchdog_restart));
`default_nettype wire
